// ---- src/radiometer_data_commutator_control.sv ----
`timescale 1ns/10ps
module radiometer_data_commutator_control #(
	parameter int ADDR_W = rdcc_pkg::COMM_ADDR_W
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// timing reference from the timing source unit
	input  wire logic              ref_clk_in,
	// scan phase strobes, one pair per scan radiometer
	input  wire logic [1:0]        data_connect_strobe,
	input  wire logic [1:0]        telemetry_connect_strobe,
	// processor activation
	output logic [1:0]             unit_active,
	// real-time channel control
	output logic                   rt_thermal_sel,
	output logic                   rt_visible_sel,
	output logic                   rt_off,
	output logic                   rt_data_gate,
	output logic                   rt_sync,
	// recorder commutation
	output logic                   rec_data_connect,
	output logic                   rec_calib,
	output logic [ADDR_W-1:0]      comm_addr,
	output logic                   thermal_marker,
	output logic                   visible_marker
);
	generate
		if (ADDR_W < 2 || ADDR_W > 8) begin : g_bad_addr_w
			$error("ADDR_W must be 2..8 so that the marker slot exists");
		end
	endgenerate

	function automatic logic [2:0] pick_output(input logic day, input logic night,
		input logic thermal, input logic visible);
		logic th;
		logic vi;
		th = night || (day && thermal);
		vi = day && !night && visible && !thermal;
		// bit2 off, bit1 visible, bit0 thermal
		pick_output = {!(day || night), vi, th};
	endfunction

	// ---------------- apb register file ----------------
	logic [rdcc_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        err_r, err_nxt;
	logic [31:0] status;
	logic        setup;
	logic        hit_ctrl;
	logic        hit_stat;

	assign setup = psel && !penable;
	assign hit_ctrl = (paddr == rdcc_pkg::CTRL_OFS);
	assign hit_stat = (paddr == rdcc_pkg::STATUS_OFS);

	always_comb begin
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		err_nxt = err_r;
		// answer is prepared in setup so access completes with no wait state
		if (setup) begin
			err_nxt = !(hit_ctrl || hit_stat) || (pwrite && hit_stat);
			prdata_nxt = 32'h0000_0000;
			if (!pwrite && hit_ctrl) begin
				prdata_nxt = {{(32-rdcc_pkg::CTRL_W){1'b0}}, ctrl_r};
			end
			if (!pwrite && hit_stat) begin
				prdata_nxt = status;
			end
		end
		if (psel && penable && pwrite && hit_ctrl) begin
			ctrl_nxt = pwdata[rdcc_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= rdcc_pkg::CTRL_RESET[rdcc_pkg::CTRL_W-1:0];
			prdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_r;

	// ---------------- reference edge and input sampling ----------------
	logic                        ref_q_r, ref_q_nxt;
	logic                        tick;
	logic [rdcc_pkg::CTRL_W-1:0] cmd_r, cmd_nxt;
	logic [1:0]                  dc_s_r, dc_s_nxt;
	logic [1:0]                  tc_s_r, tc_s_nxt;
	logic [rdcc_pkg::MARK_CNT_W-1:0] mark_r, mark_nxt;
	logic                        unit;
	logic                        dc_ev;
	logic                        tc_ev;

	// the reference is slow; its rising edge is a one-cycle tick of pclk
	assign tick = ref_clk_in && !ref_q_r;

	always_comb begin
		ref_q_nxt = ref_clk_in;
		cmd_nxt = cmd_r;
		dc_s_nxt = dc_s_r;
		tc_s_nxt = tc_s_r;
		mark_nxt = mark_r;
		if (tick) begin
			cmd_nxt = ctrl_r;
			dc_s_nxt = data_connect_strobe;
			tc_s_nxt = telemetry_connect_strobe;
			mark_nxt = mark_r + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q_r <= 1'b0;
			cmd_r <= rdcc_pkg::CTRL_RESET[rdcc_pkg::CTRL_W-1:0];
			dc_s_r <= 2'h0;
			tc_s_r <= 2'h0;
			mark_r <= '0;
		end else begin
			ref_q_r <= ref_q_nxt;
			cmd_r <= cmd_nxt;
			dc_s_r <= dc_s_nxt;
			tc_s_r <= tc_s_nxt;
			mark_r <= mark_nxt;
		end
	end

	assign unit = cmd_r[rdcc_pkg::UNIT_SEL_BIT];
	// strobes count only as new levels seen at a reference edge
	assign dc_ev = tick && data_connect_strobe[unit] && !dc_s_r[unit];
	assign tc_ev = tick && telemetry_connect_strobe[unit] && !tc_s_r[unit];

	// ---------------- sync burst generators, one per radiometer ----------------
	logic [1:0] busy_u;
	logic [1:0] sync_u;

	generate
		for (genvar u = 0; u < rdcc_pkg::UNITS; u++) begin : g_unit
			sync_burst_gen u_sync (
				.pclk     (pclk),
				.presetn  (presetn),
				.enable   (unit == u),
				.tick     (tick),
				.start    (dc_ev),
				.sync_out (sync_u[u]),
				.busy     (busy_u[u])
			);
		end
	endgenerate

	// ---------------- real-time selection and commutator ----------------
	logic [2:0]        sel_r, sel_nxt;
	logic [1:0]        act_r, act_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic              conn_r, conn_nxt;
	logic              cal_r, cal_nxt;
	logic              tmark_r, tmark_nxt;
	logic              vmark_r, vmark_nxt;
	logic              gate_r, gate_nxt;
	logic              sync_r, sync_nxt;
	logic              marker_slot;

	assign marker_slot = (addr_r == ADDR_W'(rdcc_pkg::MARKER_SLOT));

	always_comb begin
		sel_nxt = pick_output(cmd_r[rdcc_pkg::DAY_BIT], cmd_r[rdcc_pkg::NIGHT_BIT],
			cmd_r[rdcc_pkg::THERMAL_BIT], cmd_r[rdcc_pkg::VISIBLE_BIT]);
		act_nxt = unit ? 2'b10 : 2'b01;
		addr_nxt = addr_r;
		conn_nxt = conn_r;
		cal_nxt = cal_r;
		if (dc_ev) begin
			conn_nxt = 1'b1;
			cal_nxt = 1'b0;
		end else if (tc_ev) begin
			// one address register steps both commutators together
			addr_nxt = addr_r + 1'b1;
			if (addr_r + 1'b1 == ADDR_W'(rdcc_pkg::CAL_SLOT)) begin
				cal_nxt = 1'b1;
				// the calibration scan is recorded, so the data path stays on
				conn_nxt = 1'b1;
			end else begin
				conn_nxt = 1'b0;
			end
		end
		tmark_nxt = !conn_r && !cal_r && marker_slot
			&& mark_r[rdcc_pkg::MARK_THERMAL_BIT];
		vmark_nxt = !conn_r && !cal_r && marker_slot
			&& mark_r[rdcc_pkg::MARK_VISIBLE_BIT];
		gate_nxt = !busy_u[unit] && !sel_r[2];
		sync_nxt = sync_u[unit];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r <= 3'b100;
			act_r <= 2'b01;
			addr_r <= '0;
			conn_r <= 1'b1;
			cal_r <= 1'b0;
			tmark_r <= 1'b0;
			vmark_r <= 1'b0;
			gate_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			act_r <= act_nxt;
			addr_r <= addr_nxt;
			conn_r <= conn_nxt;
			cal_r <= cal_nxt;
			tmark_r <= tmark_nxt;
			vmark_r <= vmark_nxt;
			gate_r <= gate_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign unit_active = act_r;
	assign rt_thermal_sel = sel_r[0];
	assign rt_visible_sel = sel_r[1];
	assign rt_off = sel_r[2];
	assign rt_data_gate = gate_r;
	assign rt_sync = sync_r;
	assign rec_data_connect = conn_r;
	assign rec_calib = cal_r;
	assign comm_addr = addr_r;
	assign thermal_marker = tmark_r;
	assign visible_marker = vmark_r;

	always_comb begin
		status = 32'h0000_0000;
		status[rdcc_pkg::ST_THERMAL_BIT] = sel_r[0];
		status[rdcc_pkg::ST_VISIBLE_BIT] = sel_r[1];
		status[rdcc_pkg::ST_OFF_BIT] = sel_r[2];
		status[rdcc_pkg::ST_BUSY_BIT] = busy_u[unit];
		status[rdcc_pkg::ST_DATA_BIT] = conn_r;
		status[rdcc_pkg::ST_CALIB_BIT] = cal_r;
		status[rdcc_pkg::ST_ADDR_LSB +: ADDR_W] = addr_r;
	end

	off_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!cmd_r[rdcc_pkg::DAY_BIT] && !cmd_r[rdcc_pkg::NIGHT_BIT]) |=> (rt_off && !rt_thermal_sel
		&& !rt_visible_sel))
		else $error("real-time output not forced off");
	night_thermal_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_r[rdcc_pkg::NIGHT_BIT] |=> (rt_thermal_sel && !rt_visible_sel))
		else $error("night selection not thermal only");
	one_active_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(unit_active) && !busy_u[!unit_active[1]] && !sync_u[!unit_active[1]])
		else $error("inactive processor is running");
	data_reconnect_a: assert property (@(posedge pclk) disable iff (!presetn)
		dc_ev |=> rec_data_connect && !rec_calib)
		else $error("data not reconnected on data-connect strobe");
	telemetry_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tc_ev && !dc_ev) |=> (comm_addr == $past(comm_addr) + 1'b1)
		&& (rec_data_connect == (comm_addr == ADDR_W'(rdcc_pkg::CAL_SLOT))))
		else $error("telemetry commutation wrong at housing scan start");
	marker_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
		(thermal_marker || visible_marker) |-> $past(marker_slot && !conn_r))
		else $error("marker outside commutator slot 2");
	burst_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_u[unit] |=> !rt_data_gate)
		else $error("data path open during sync burst");
	apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !$past(hit_ctrl) && !$past(hit_stat) && $stable(paddr)) |-> pslverr)
		else $error("unmapped access not flagged");
endmodule

// ---- shared/rdcc_pkg.sv ----
// Overview of operation
// - only the processor paired with the radiometer in use runs; the other idles
// - night passes thermal only; day passes visible or thermal per command
// - seven 300 Hz sync pulses precede each scan line, after housing scan
// - housing scan swaps recorder data for telemetry, except one calibration scan
// - one shared address register steps both commutators together
// - data-connect strobe at housing scan end reconnects data to recorders
// - telemetry-connect strobe at housing scan start switches recorders to telemetry
// - commutator slot 2 carries marker: 300 Hz thermal, 150 Hz visible
// - thermal if night or day+thermal; visible if day+visible with neither night nor thermal; off if neither day nor night
// - sequencer starts next reference edge; divide by eight, preset while idle
package rdcc_pkg;
	// register map, byte addresses
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  STATUS_OFS  = 8'h04;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	// control fields
	localparam int UNIT_SEL_BIT = 0;
	localparam int DAY_BIT      = 1;
	localparam int NIGHT_BIT    = 2;
	localparam int THERMAL_BIT  = 3;
	localparam int VISIBLE_BIT  = 4;
	localparam int CTRL_W       = 5;
	// status fields
	localparam int ST_THERMAL_BIT = 0;
	localparam int ST_VISIBLE_BIT = 1;
	localparam int ST_OFF_BIT     = 2;
	localparam int ST_BUSY_BIT    = 3;
	localparam int ST_DATA_BIT    = 4;
	localparam int ST_CALIB_BIT   = 5;
	localparam int ST_ADDR_LSB    = 8;
	// timing: reference rate and derived dividers
	localparam int REF_HZ          = 2400;
	localparam int SYNC_HZ         = 300;
	localparam int SYNC_DIV        = REF_HZ / SYNC_HZ;
	localparam int DIV_W           = $clog2(SYNC_DIV);
	localparam logic [2:0] DIV_PRESET  = 3'h7;
	localparam logic [3:0] SYNC_PULSES = 4'h7;
	// marker tones taken from a free counter on reference edges
	localparam int MARK_CNT_W      = 4;
	localparam int MARK_THERMAL_BIT = 2;
	localparam int MARK_VISIBLE_BIT = 3;
	// commutator
	localparam int COMM_ADDR_W  = 4;
	localparam int MARKER_SLOT  = 2;
	localparam int CAL_SLOT     = 0;
	localparam int UNITS        = 2;

	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_ARM   = 3'b010,
		SEQ_BURST = 3'b100
	} seq_state_t;
endpackage

// ---- src/sync_burst_gen.sv ----
`timescale 1ns/10ps
module sync_burst_gen (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic enable,
	input  wire logic tick,
	input  wire logic start,
	// burst outputs
	output logic      sync_out,
	output logic      busy
);
	rdcc_pkg::seq_state_t state_r, state_nxt;
	logic [2:0] div_r, div_nxt;
	logic [3:0] pcnt_r, pcnt_nxt;
	logic       sync_r, sync_nxt;

	always_comb begin
		state_nxt = state_r;
		div_nxt = div_r;
		pcnt_nxt = pcnt_r;
		sync_nxt = 1'b0;
		case (state_r)
			rdcc_pkg::SEQ_IDLE: begin
				div_nxt = rdcc_pkg::DIV_PRESET;
				pcnt_nxt = 4'h0;
				if (enable && tick && start) begin
					state_nxt = rdcc_pkg::SEQ_ARM;
				end
			end
			rdcc_pkg::SEQ_ARM: begin
				div_nxt = rdcc_pkg::DIV_PRESET;
				if (tick) begin
					state_nxt = rdcc_pkg::SEQ_BURST;
					div_nxt = div_r + 3'h1;
				end
			end
			rdcc_pkg::SEQ_BURST: begin
				if (tick) begin
					div_nxt = div_r + 3'h1;
					if (div_r == rdcc_pkg::DIV_PRESET) begin
						pcnt_nxt = pcnt_r + 4'h1;
						if (pcnt_r + 4'h1 == rdcc_pkg::SYNC_PULSES) begin
							state_nxt = rdcc_pkg::SEQ_IDLE;
						end
					end
				end
			end
			default: begin
				state_nxt = rdcc_pkg::SEQ_IDLE;
			end
		endcase
		// taken from the next divider value so the first pulse of a burst is full width
		sync_nxt = (state_nxt == rdcc_pkg::SEQ_BURST) && !div_nxt[2];
		// a deselected unit drops out at once, not at the end of its burst
		if (!enable) begin
			state_nxt = rdcc_pkg::SEQ_IDLE;
			sync_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rdcc_pkg::SEQ_IDLE;
			div_r <= rdcc_pkg::DIV_PRESET;
			pcnt_r <= 4'h0;
			sync_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			pcnt_r <= pcnt_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
	assign busy = (state_r == rdcc_pkg::SEQ_BURST);

	preset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == rdcc_pkg::SEQ_IDLE) |=> (div_r == 3'h7))
		else $error("divider not preset while idle");
	arm_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_r == rdcc_pkg::SEQ_ARM) |-> $past(tick && start && enable))
		else $error("sequencer armed without strobe on a reference edge");
	pulse_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == rdcc_pkg::SEQ_BURST) |-> (pcnt_r < 4'h7))
		else $error("more than seven sync pulses");
	sync_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r != rdcc_pkg::SEQ_BURST) |-> !sync_r)
		else $error("sync pulse outside a burst");
endmodule

// ---- sim/rdcc_partner.sv ----
`timescale 1ns/10ps
module rdcc_partner (
	// clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// timing unit and radiometer outputs
	output logic       ref_clk_in,
	output logic [1:0] data_connect_strobe,
	output logic [1:0] telemetry_connect_strobe
);
	logic [1:0] ref_cnt_r;
	// reference runs free, sped up to one rise every 8 cycles to keep runs short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_r  <= 2'h0;
			ref_clk_in <= 1'b0;
		end else begin
			ref_cnt_r <= ref_cnt_r + 2'h1;
			if (ref_cnt_r == 2'h3) begin
				ref_clk_in <= ~ref_clk_in;
			end
		end
	end
	initial begin
		data_connect_strobe = 2'h0;
		telemetry_connect_strobe = 2'h0;
	end
	// held over two reference rises so one tick always sees the level
	task automatic strobe(input logic dc, input int u);
		logic [1:0] m;
		m = 2'h1 << u;
		@(posedge pclk);
		if (dc) begin
			data_connect_strobe <= data_connect_strobe | m;
		end else begin
			telemetry_connect_strobe <= telemetry_connect_strobe | m;
		end
		repeat (16) @(posedge pclk);
		data_connect_strobe <= 2'h0;
		telemetry_connect_strobe <= 2'h0;
	endtask
endmodule

// ---- sim/radiometer_data_commutator_control_test.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module radiometer_data_commutator_control_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_clk_in;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  dcs, tcs, unit_active;
	logic        t_sel, v_sel, off, gate, sync, rec_dc, calib, tm, vm, e;
	logic [3:0]  comm_addr;
	logic [4:0]  c;
	int          errors, tests_run, cyc, nt, nv, rises, hi, ovl, a;

	radiometer_data_commutator_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
		.data_connect_strobe(dcs), .telemetry_connect_strobe(tcs), .unit_active(unit_active),
		.rt_thermal_sel(t_sel), .rt_visible_sel(v_sel), .rt_off(off), .rt_data_gate(gate),
		.rt_sync(sync), .rec_data_connect(rec_dc), .rec_calib(calib), .comm_addr(comm_addr),
		.thermal_marker(tm), .visible_marker(vm));
	rdcc_partner i_partner (.pclk(pclk), .presetn(presetn), .ref_clk_in(ref_clk_in),
		.data_connect_strobe(dcs), .telemetry_connect_strobe(tcs));

	always #2 pclk = ~pclk;

	task automatic print_verdict();
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// the run needs about 3700 cycles, so this only trips on a hang
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [2:0] sel_exp(input logic [4:0] k);
		logic th;
		th = k[2] | (k[1] & k[3]);
		return {~(k[1] | k[2]), k[1] & k[4] & ~th, th};
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	// counts marker toggles, sync pulses and gate overlap over a fixed window
	task automatic watch(input int n);
		logic pt, pv, ps;
		nt = 0;
		nv = 0;
		rises = 0;
		hi = 0;
		ovl = 0;
		@(negedge pclk);
		{pt, pv, ps} = {tm, vm, sync};
		repeat (n) begin
			@(negedge pclk);
			nt += (tm !== pt);
			nv += (vm !== pv);
			rises += (sync === 1'b1 && ps === 1'b0);
			hi += (sync === 1'b1 && rises == 1);
			ovl += (sync === 1'b1 && gate === 1'b1);
			{pt, pv, ps} = {tm, vm, sync};
		end
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		tests_run = 0;
		cyc = 0;
		void'($urandom(43003));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		settle(0);
		`CHK("unit_active", 2'h1, unit_active);
		`CHK("rt_off", 1'b1, off);
		`CHK("comm_addr", 4'h0, comm_addr);
		apb(1'b0, rdcc_pkg::CTRL_OFS, 32'h0);
		`CHK("ctrl", rdcc_pkg::CTRL_RESET, r);
		apb(1'b1, rdcc_pkg::STATUS_OFS, 32'h1F);
		`CHK("pslverr", 1'b1, e);
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {e, r});
		for (int i = 0; i < 40; i++) begin
			c = (i < 32) ? 5'(i) : 5'($urandom);
			c[0] = 1'b0;
			apb(1'b1, rdcc_pkg::CTRL_OFS, {27'h0, c});
			settle(24);
			`CHK("select", sel_exp(c), {off, v_sel, t_sel});
			apb(1'b0, rdcc_pkg::STATUS_OFS, 32'h0);
			`CHK("status", sel_exp(c), r[2:0]);
		end
		i_partner.strobe(1'b0, 1);
		settle(4);
		`CHK("idle unit", 4'h0, comm_addr);
		apb(1'b1, rdcc_pkg::CTRL_OFS, 32'h0B);
		settle(24);
		`CHK("unit_active", 2'h2, unit_active);
		apb(1'b1, rdcc_pkg::CTRL_OFS, 32'h0A);
		settle(24);
		for (int s = 1; s <= 17; s++) begin
			i_partner.strobe(1'b0, 0);
			settle(4);
			a = s % 16;
			`CHK("comm_addr", 4'(a), comm_addr);
			`CHK("rec_calib", (a == rdcc_pkg::CAL_SLOT), calib);
			if (a != rdcc_pkg::CAL_SLOT) `CHK("rec_dc", 1'b0, rec_dc);
			if (a == 2 || a == 3) begin
				if (a == 3) begin
					apb(1'b0, rdcc_pkg::STATUS_OFS, 32'h0);
					`CHK("status", 6'h0D, {r[11:8], r[4:3]});
					`CHK("gate off", 1'b0, gate);
				end
				watch(512);
				if (a == 2) begin
					`CHK("thermal tone", 1'b1, (nt >= 15 && nt <= 17));
					`CHK("visible tone", 1'b1, (nv >= 7 && nv <= 9));
				end else begin
					`CHK("no marker", 0, nt + nv);
				end
			end
			if (s == 1) begin
				fork
					i_partner.strobe(1'b1, 0);
					watch(600);
				join
				`CHK("sync pulses", 7, rises);
				`CHK("pulse width", 32, hi);
				`CHK("gate in burst", 0, ovl);
				`CHK("gate after", 1'b1, gate);
			end else begin
				i_partner.strobe(1'b1, 0);
			end
			settle(4);
			`CHK("rec_dc", 1'b1, rec_dc);
			`CHK("rec_calib", 1'b0, calib);
		end
		print_verdict();
	end
endmodule
